// file: rpm_pkg.sv
// Shared constants for the reset and power-mode controller and its host.
// Assumes one 125 MHz clock shared by both ends.
`default_nettype none
package rpm_pkg;
	localparam int         ADDR_W          = 16;
	localparam int         DATA_W          = 16;
	localparam logic [15:0] OFS_SOFT_RESET = 16'h0424;
	localparam logic [15:0] OFS_CAUSE      = 16'h0A40;
	localparam logic [15:0] OFS_KEY        = 16'h0A5C;
	localparam logic [15:0] OFS_PWR_MODE   = 16'h0A00;
	localparam logic [15:0] OFS_RETAIN     = 16'h0A10;
	localparam logic [15:0] OFS_CLOCK_CFG  = 16'h0A14;
	localparam logic [15:0] KEY_UNLOCK     = 16'h12EA;
	localparam logic [15:0] SOFT_TRIGGER   = 16'hA158;
	localparam logic [15:0] SOFT_RST_VAL   = 16'h0001;
	localparam logic [15:0] PWR_MODE_RST   = 16'h0001;
	localparam logic [1:0]  MODE_ACTIVE    = 2'h1;
	localparam logic [1:0]  MODE_HIBERNATE = 2'h2;
	localparam int          BIT_POR        = 0;
	localparam int          BIT_PIN        = 1;
	localparam int          BIT_SOFT       = 3;
	localparam int          BIT_ADC_KEEP   = 14;
	localparam int          BIT_HIGH_POWER = 0;
	localparam int          BIT_OSC_32M    = 1;
	localparam int          BIT_KEEP_BIAS  = 0;
	localparam int          BIT_KEEP_SW    = 1;
	localparam int          BIT_SHUTDOWN   = 2;
	localparam logic [15:0] BW_HIGH_POWER  = 16'h000D;
	localparam logic [15:0] CAUSE_MASK     = 16'h000B;
	localparam logic [15:0] PWR_MODE_MASK  = 16'hC00F;
	localparam logic [15:0] ZERO16         = 16'h0000;
	typedef enum logic [2:0] {
		RPM_H_IDLE   = 3'b000,
		RPM_H_KEY    = 3'b001,
		RPM_H_SOFT   = 3'b010,
		RPM_H_BW     = 3'b011,
		RPM_H_CLK    = 3'b100,
		RPM_H_FILT   = 3'b101,
		RPM_H_SINGLE = 3'b110
	} rpm_host_state_t;
endpackage
`default_nettype wire

// file: rpm_if.sv
// Register port and reset pin between host and controller.
// Assumes both ends share clock_i.
`timescale 1ns/1ps
`default_nettype none
interface rpm_if;
	logic                 wr_en;
	logic                 rd_en;
	logic [15:0]          addr;
	logic [15:0]          wdata;
	logic [15:0]          rdata;
	logic                 rvalid;
	logic                 pin_rst_n;
	modport dev  (input wr_en, rd_en, addr, wdata, pin_rst_n, output rdata, rvalid);
	modport host (output wr_en, rd_en, addr, wdata, pin_rst_n, input rdata, rvalid);
endinterface
`default_nettype wire

// file: rpm_dev.sv
// Reset and power-mode controller, device end of the register port.
// Assumes the host keeps writes one per cycle; por_n_i comes from the supply monitor.
//
// What this block does
// - Accept pin, power-on and software resets.
// - Soft reset spares low-power amplifier state.
// - Pin low resets the state registers except the cause flags, which are kept; the output registers are not reset by it.
// - Soft reset register needs unlock key.
// - Other register write re-locks key.
// - Trigger value starts soft reset; zero none.
// - Soft flag bit 3 sets on write.
// - Pin flag bit 1 sets on pin reset.
// - Power-on flag bit 0 sets on power-up.
// - Option keeps sensor bias through soft reset.
// - Switch settings may survive soft reset.
// - Two power modes supported: active and hibernate.
// - Host sequences high-power entry steps.
// - Default active normal, 16 MHz, mode 1.
// - Host writes 2 for hibernate.
// - Hibernate stops fast clock, gates blocks.
// - Watchdog runs in hibernate.
// - Host keeps bit 14 low.
// - Hibernate may keep sensor bias alive.
// - Host powers down analog in shutdown.
// - Host drives reset pin from output.
// - Mode field 01 active, 10 hibernate.
`timescale 1ns/1ps
`default_nettype none
module rpm_dev (
	input  wire logic  clock_i,
	input  wire logic  rst_n_i,
	input  wire logic  clk_en_i,
	input  wire logic  por_n_i,
	input  wire logic  sw_in_i,
	rpm_if.dev         bus,
	output logic       soft_rst_o,
	output logic       fast_clk_en_o,
	output logic       osc_32m_o,
	output logic       block_clk_en_o,
	output logic       slow_osc_en_o,
	output logic       watchdog_en_o,
	output logic       adc_switch_o,
	output logic       bias_keep_o,
	output logic       analog_pd_o,
	output logic       sw_state_o,
	output logic [1:0] power_mode_o
);
	import rpm_pkg::*;

	logic        unlocked_q, unlocked_d;
	logic [15:0] soft_q, soft_d;
	logic [15:0] cause_q, cause_d;
	logic [15:0] mode_q, mode_d;
	logic [15:0] retain_q, retain_d;
	logic [15:0] clkcfg_q, clkcfg_d;
	logic [15:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic        soft_pulse_q, soft_pulse_d;
	logic        sw_q, sw_d;
	logic        pin_rst;
	logic        wr_soft;

	// ----------------------------------------
	// Reset sources and register writes
	// ----------------------------------------
	// Pin and power-on as hard reset.
	assign pin_rst = !bus.pin_rst_n;
	assign wr_soft = bus.wr_en && (bus.addr == OFS_SOFT_RESET);

	always_comb begin
		unlocked_d   = unlocked_q;
		soft_d       = soft_q;
		cause_d      = cause_q;
		mode_d       = mode_q;
		retain_d     = retain_q;
		clkcfg_d     = clkcfg_q;
		soft_pulse_d = 1'b0;
		sw_d         = sw_q;
		rdata_d      = ZERO16;
		rvalid_d     = bus.rd_en;
		if (!retain_q[BIT_KEEP_SW]) begin
			sw_d = sw_in_i;
		end
		if (bus.wr_en) begin
			if (bus.addr == OFS_KEY) begin
				unlocked_d = (bus.wdata == KEY_UNLOCK);
			end else if (wr_soft) begin
				unlocked_d = 1'b0;
				if (unlocked_q) begin
					// Only bit 0 is stored, so the upper bits read back as zero.
					soft_d = bus.wdata & SOFT_RST_VAL;
					cause_d[BIT_SOFT] = 1'b1;
					soft_pulse_d = (bus.wdata == SOFT_TRIGGER);
				end
			end else begin
				unlocked_d = 1'b0;
				if (bus.addr == OFS_CAUSE) begin
					cause_d = cause_q & ~(bus.wdata & CAUSE_MASK);
				end else if (bus.addr == OFS_PWR_MODE) begin
					mode_d = bus.wdata & PWR_MODE_MASK;
				end else if (bus.addr == OFS_RETAIN) begin
					retain_d = bus.wdata;
				end else if (bus.addr == OFS_CLOCK_CFG) begin
					clkcfg_d = bus.wdata;
				end
			end
		end
		// Hardware sets after clears so a same-cycle event is kept.
		if (soft_pulse_q) begin
			cause_d[BIT_SOFT] = 1'b1;
		end
		if (soft_pulse_q) begin
			// Bias and retain kept on soft reset.
			soft_d  = SOFT_RST_VAL;
			mode_d  = PWR_MODE_RST;
			clkcfg_d = ZERO16;
			retain_d = retain_q;
		end
		if (bus.rd_en) begin
			if (bus.addr == OFS_SOFT_RESET) begin
				rdata_d = soft_q;
			end else if (bus.addr == OFS_CAUSE) begin
				rdata_d = cause_q & CAUSE_MASK;
			end else if (bus.addr == OFS_PWR_MODE) begin
				rdata_d = mode_q;
			end else if (bus.addr == OFS_RETAIN) begin
				rdata_d = retain_q;
			end else if (bus.addr == OFS_CLOCK_CFG) begin
				rdata_d = clkcfg_q;
			end else begin
				rdata_d = ZERO16;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!por_n_i) begin
			unlocked_q   <= 1'b0;
			soft_q       <= SOFT_RST_VAL;
			cause_q      <= 16'h0001;
			mode_q       <= PWR_MODE_RST;
			retain_q     <= ZERO16;
			clkcfg_q     <= ZERO16;
			rdata_q      <= ZERO16;
			rvalid_q     <= 1'b0;
			soft_pulse_q <= 1'b0;
			sw_q         <= 1'b0;
		end else if (!rst_n_i || pin_rst) begin
			unlocked_q   <= 1'b0;
			soft_q       <= SOFT_RST_VAL;
			// Pin flag set, earlier flags kept.
			cause_q      <= pin_rst ? (cause_q | 16'h0002) : cause_q;
			mode_q       <= PWR_MODE_RST;
			retain_q     <= ZERO16;
			clkcfg_q     <= ZERO16;
			rdata_q      <= ZERO16;
			rvalid_q     <= 1'b0;
			soft_pulse_q <= 1'b0;
			sw_q         <= 1'b0;
		end else if (clk_en_i) begin
			unlocked_q   <= unlocked_d;
			soft_q       <= soft_d;
			cause_q      <= cause_d;
			mode_q       <= mode_d;
			retain_q     <= retain_d;
			clkcfg_q     <= clkcfg_d;
			rdata_q      <= rdata_d;
			rvalid_q     <= rvalid_d;
			soft_pulse_q <= soft_pulse_d;
			sw_q         <= sw_d;
		end
	end

	// ----------------------------------------
	// Power-mode outputs
	// ----------------------------------------
	logic hib;
	always_comb begin
		hib = (mode_q[1:0] == MODE_HIBERNATE);
	end

	// Outputs are registered copies so none glitch on a mode write.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			soft_rst_o     <= 1'b0;
			fast_clk_en_o  <= 1'b1;
			osc_32m_o      <= 1'b0;
			block_clk_en_o <= 1'b1;
			slow_osc_en_o  <= 1'b1;
			watchdog_en_o  <= 1'b1;
			adc_switch_o   <= 1'b0;
			bias_keep_o    <= 1'b0;
			analog_pd_o    <= 1'b0;
			sw_state_o     <= 1'b0;
			power_mode_o   <= PWR_MODE_RST[1:0];
			bus.rdata      <= ZERO16;
			bus.rvalid     <= 1'b0;
		end else if (clk_en_i) begin
			soft_rst_o     <= soft_pulse_q;
			// Hibernate stops fast clock and gates blocks.
			fast_clk_en_o  <= !hib;
			block_clk_en_o <= !hib;
			osc_32m_o      <= !hib && clkcfg_q[BIT_OSC_32M];
			slow_osc_en_o  <= 1'b1;
			watchdog_en_o  <= 1'b1;
			adc_switch_o   <= !hib || mode_q[BIT_ADC_KEEP];
			bias_keep_o    <= retain_q[BIT_KEEP_BIAS];
			analog_pd_o    <= hib && retain_q[BIT_SHUTDOWN];
			sw_state_o     <= sw_q;
			power_mode_o   <= mode_q[1:0];
			bus.rdata      <= rdata_q;
			bus.rvalid     <= rvalid_q;
		end
	end
endmodule // rpm_dev
`default_nettype wire

// file: rpm_host.sv
// Host end: turns user commands into register writes and drives the reset pin.
// Assumes the device end answers reads two cycles after the request.
`timescale 1ns/1ps
`default_nettype none
module rpm_host (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        clk_en_i,
	rpm_if.host              bus,
	input  wire logic        pin_rst_i,
	input  wire logic        soft_rst_req_i,
	input  wire logic        high_power_req_i,
	input  wire logic        wr_req_i,
	input  wire logic        rd_req_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	output logic             busy_o,
	output logic [15:0]      rdata_o,
	output logic             rvalid_o
);
	import rpm_pkg::*;

	rpm_host_state_t st_q, st_d;
	logic        wr_d, rd_d;
	logic [15:0] a_d, w_d;

	always_comb begin
		st_d = st_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		a_d  = ZERO16;
		w_d  = ZERO16;
		case (st_q)
			RPM_H_IDLE: begin
				if (soft_rst_req_i) begin
					wr_d = 1'b1;
					a_d  = OFS_KEY;
					w_d  = KEY_UNLOCK;
					st_d = RPM_H_SOFT;
				end else if (high_power_req_i) begin
					st_d = RPM_H_BW;
				end else if (wr_req_i || rd_req_i) begin
					// Hibernate is a plain mode write; caller keeps bit 14 low.
					wr_d = wr_req_i;
					rd_d = rd_req_i && !wr_req_i;
					a_d  = addr_i;
					w_d  = wdata_i;
					st_d = RPM_H_SINGLE;
				end
			end
			RPM_H_SOFT: begin
				wr_d = 1'b1;
				a_d  = OFS_SOFT_RESET;
				w_d  = SOFT_TRIGGER;
				st_d = RPM_H_SINGLE;
			end
			RPM_H_BW: begin
				wr_d = 1'b1;
				a_d  = OFS_CLOCK_CFG;
				w_d  = BW_HIGH_POWER;
				st_d = RPM_H_CLK;
			end
			RPM_H_CLK: begin
				wr_d = 1'b1;
				a_d  = OFS_CLOCK_CFG;
				w_d  = BW_HIGH_POWER | 16'h0002;
				st_d = RPM_H_FILT;
			end
			RPM_H_FILT: begin
				wr_d = 1'b1;
				a_d  = OFS_CLOCK_CFG;
				w_d  = BW_HIGH_POWER | 16'h0003;
				st_d = RPM_H_SINGLE;
			end
			default: begin
				st_d = RPM_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st_q          <= RPM_H_IDLE;
			bus.wr_en     <= 1'b0;
			bus.rd_en     <= 1'b0;
			bus.addr      <= ZERO16;
			bus.wdata     <= ZERO16;
			bus.pin_rst_n <= 1'b1;
			busy_o        <= 1'b0;
			rdata_o       <= ZERO16;
			rvalid_o      <= 1'b0;
		end else if (clk_en_i) begin
			st_q          <= st_d;
			bus.wr_en     <= wr_d;
			bus.rd_en     <= rd_d;
			bus.addr      <= a_d;
			bus.wdata     <= w_d;
			// Reset pin from a host output.
			bus.pin_rst_n <= !pin_rst_i;
			busy_o        <= (st_d != RPM_H_IDLE);
			rdata_o       <= bus.rdata;
			rvalid_o      <= bus.rvalid;
		end
	end
endmodule // rpm_host
`default_nettype wire

// file: rpm_checker.sv
// Checker for the register port between the host end and the controller end.
// Assumes one clock domain and that it sees only the interface signals.
`timescale 1ns/1ps
`default_nettype none
module rpm_checker
	import rpm_pkg::*;
(
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        rvalid,
	input wire logic        pin_rst_n
);
	logic [15:0] ra1_d, ra1_q, ra2_d, ra2_q;
	logic        key_d, key_q, pin_d, pin_q, soft_d, soft_q;
	logic        clr_pin, clr_soft, mapped;
	// Flags only ever demand a set bit, so a reset that clears them cannot cause false alarms.
	always_comb begin
		clr_pin  = wr_en && addr == OFS_CAUSE && wdata[BIT_PIN];
		clr_soft = wr_en && addr == OFS_CAUSE && wdata[BIT_SOFT];
		ra1_d    = addr;
		ra2_d    = ra1_q;
		key_d    = pin_rst_n && (wr_en ? (addr == OFS_KEY && wdata == KEY_UNLOCK) : key_q);
		pin_d    = !pin_rst_n || (pin_q && !clr_pin);
		soft_d   = (key_q && wr_en && addr == OFS_SOFT_RESET) || (soft_q && !clr_soft);
		mapped   = ra2_q inside {OFS_SOFT_RESET, OFS_CAUSE, OFS_KEY, OFS_PWR_MODE,
			OFS_RETAIN, OFS_CLOCK_CFG};
	end
	always_ff @(posedge clock_i) begin
		ra1_q  <= ra1_d;
		ra2_q  <= ra2_d;
		key_q  <= rst_n_i && key_d;
		pin_q  <= rst_n_i && pin_d;
		soft_q <= rst_n_i && soft_d;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_read_latency: assert property (rd_en |-> ##2 rvalid)
		else $error("read answer not two cycles after request");
	a_read_origin: assert property (rvalid |-> $past(rd_en, 2))
		else $error("read answer without request");
	a_unmapped_zero: assert property (rvalid && !mapped |-> rdata == ZERO16)
		else $error("unmapped read not zero");
	a_cause_resvd: assert property (rvalid && ra2_q == OFS_CAUSE |-> (rdata & ~CAUSE_MASK) == ZERO16)
		else $error("cause flags reserved bits set");
	a_soft_resvd: assert property (rvalid && ra2_q == OFS_SOFT_RESET |-> rdata[15:1] == 15'h0)
		else $error("soft reset register reserved bits set");
	a_mode_resvd: assert property (rvalid && ra2_q == OFS_PWR_MODE |-> (rdata & ~PWR_MODE_MASK) == ZERO16 && rdata[1:0] != 2'h3)
		else $error("power mode read bad");
	a_pin_flag: assert property (rvalid && ra2_q == OFS_CAUSE && pin_q |-> rdata[BIT_PIN])
		else $error("pin reset flag missing");
	a_soft_flag: assert property (rvalid && ra2_q == OFS_CAUSE && soft_q |-> rdata[BIT_SOFT])
		else $error("soft reset flag missing");
endmodule // rpm_checker
`default_nettype wire

// file: reset_and_power_mode_control_bench.sv
// Self-checking bench: host end and controller end joined by the interface.
// Assumes the host raises busy_o until each requested transfer is done.
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_mode_control_bench;
	import rpm_pkg::*;
	logic        clock_i, rst_n_i, clk_en_i, por_n_i, sw_in_i, pin_rst_i, busy_o, rvalid_o;
	logic        soft_rst_req_i, high_power_req_i, wr_req_i, rd_req_i, soft_rst_o;
	logic        fast_clk_en_o, osc_32m_o, block_clk_en_o, slow_osc_en_o, watchdog_en_o;
	logic [15:0] addr_i, wdata_i, rdata_o, ua;
	logic [1:0]  power_mode_o;
	logic        adc_switch_o, bias_keep_o, analog_pd_o, sw_state_o, sw_hold;
	int          errors, n_tests, pulses, p0;
	logic [15:0] exp_q[$];
	rpm_if bus_if();
	rpm_host i_rpm_host(.clock_i, .rst_n_i, .clk_en_i, .bus(bus_if), .pin_rst_i, .soft_rst_req_i,
		.high_power_req_i, .wr_req_i, .rd_req_i, .addr_i, .wdata_i, .busy_o, .rdata_o, .rvalid_o);
	rpm_dev i_rpm_dev(.clock_i, .rst_n_i, .clk_en_i, .por_n_i, .sw_in_i, .bus(bus_if), .soft_rst_o,
		.fast_clk_en_o, .osc_32m_o, .block_clk_en_o, .slow_osc_en_o, .watchdog_en_o,
		.adc_switch_o, .bias_keep_o, .analog_pd_o, .sw_state_o, .power_mode_o);
	rpm_checker i_rpm_checker(.clock_i, .rst_n_i, .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid),
		.pin_rst_n(bus_if.pin_rst_n));
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	task automatic wrap_up;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic settle;
		int k;
		k = 0;
		@(negedge clock_i);
		while (busy_o !== 1'b0 && k < 60) begin
			@(negedge clock_i);
			k++;
		end
		if (k >= 60) begin
			errors++;
			wrap_up;
		end
		repeat (4) @(negedge clock_i);
	endtask
	task automatic req(input logic [15:0] a, input logic [15:0] d, input logic w);
		addr_i = a;
		wdata_i = d;
		wr_req_i = w;
		rd_req_i = !w;
		@(negedge clock_i);
		wr_req_i = 1'b0;
		rd_req_i = 1'b0;
		settle;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		req(a, ZERO16, 1'b0);
	endtask
	task automatic pulse_req(ref logic r);
		r = 1'b1;
		@(negedge clock_i);
		r = 1'b0;
		settle;
	endtask
	// Oldest expected read value is matched to each answer; samples away from the edge.
	always @(negedge clock_i) begin
		sw_in_i <= 1'($urandom);
		if (soft_rst_o === 1'b1) pulses++;
		if (rvalid_o === 1'b1) chk(rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 16'hDEAD);
	end
	initial begin
		{errors, n_tests, pulses} = '0;
		{rst_n_i, por_n_i, pin_rst_i, soft_rst_req_i, high_power_req_i} = '0;
		{wr_req_i, rd_req_i, addr_i, wdata_i, sw_in_i} = '0;
		clk_en_i = 1'b1;
		ua = 16'($urandom(32'h2A32));
		repeat (6) @(negedge clock_i);
		{rst_n_i, por_n_i} = 2'b11;
		repeat (2) @(negedge clock_i);
		chk({14'h0, power_mode_o}, 16'h0001);
		chk({12'h0, fast_clk_en_o, block_clk_en_o, slow_osc_en_o, watchdog_en_o}, 16'h000F);
		rd(OFS_CAUSE, 16'h0001);
		rd(OFS_SOFT_RESET, SOFT_RST_VAL);
		rd(OFS_PWR_MODE, PWR_MODE_RST);
		req(OFS_CAUSE, 16'h0001, 1'b1);
		rd(OFS_CAUSE, ZERO16);
		p0 = pulses;
		req(OFS_SOFT_RESET, SOFT_TRIGGER, 1'b1);
		req(OFS_KEY, KEY_UNLOCK, 1'b1);
		req(OFS_PWR_MODE, 16'h0002, 1'b1);
		req(OFS_SOFT_RESET, SOFT_TRIGGER, 1'b1);
		chk(16'(pulses - p0), ZERO16);
		rd(OFS_CAUSE, ZERO16);
		chk({14'h0, power_mode_o}, 16'h0002);
		chk({12'h0, fast_clk_en_o, block_clk_en_o, slow_osc_en_o, watchdog_en_o}, 16'h0003);
		rd(OFS_PWR_MODE, 16'h0002);
		pulse_req(soft_rst_req_i);
		chk(16'(pulses - p0), 16'h0001);
		chk({14'h0, power_mode_o}, 16'h0001);
		rd(OFS_CAUSE, 16'h0008);
		req(OFS_SOFT_RESET, SOFT_TRIGGER, 1'b1);
		req(OFS_CAUSE, 16'h0008, 1'b1);
		req(OFS_KEY, KEY_UNLOCK, 1'b1);
		req(OFS_SOFT_RESET, ZERO16, 1'b1);
		chk(16'(pulses - p0), 16'h0001);
		rd(OFS_CAUSE, 16'h0008);
		req(OFS_CAUSE, 16'h0008, 1'b1);
		pulse_req(high_power_req_i);
		chk({15'h0, osc_32m_o}, 16'h0001);
		req(OFS_PWR_MODE, 16'h0002, 1'b1);
		pin_rst_i = 1'b1;
		repeat (3) @(negedge clock_i);
		pin_rst_i = 1'b0;
		repeat (3) @(negedge clock_i);
		chk({14'h0, power_mode_o}, 16'h0001);
		chk({15'h0, osc_32m_o}, ZERO16);
		rd(OFS_CAUSE, 16'h0002);
		clk_en_i = 1'b0;
		req(OFS_PWR_MODE, 16'h0002, 1'b1);
		clk_en_i = 1'b1;
		repeat (2) @(negedge clock_i);
		chk({14'h0, power_mode_o}, 16'h0001);
		rd(OFS_PWR_MODE, PWR_MODE_RST);
		req(OFS_RETAIN, 16'h0005, 1'b1);
		req(OFS_PWR_MODE, 16'h0002, 1'b1);
		chk({13'h0, bias_keep_o, analog_pd_o, adc_switch_o}, 16'h0006);
		req(OFS_RETAIN, 16'h0002, 1'b1);
		sw_hold = sw_state_o;
		repeat (8) begin
			@(negedge clock_i);
			chk({15'h0, sw_state_o}, {15'h0, sw_hold});
		end
		pulse_req(soft_rst_req_i);
		rd(OFS_RETAIN, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			ua = 16'h3000 | 16'($urandom_range(16'h0FFF));
			req(ua, ua, 1'b1);
			rd(ua, ZERO16);
		end
		chk(16'(exp_q.size()), ZERO16);
		wrap_up;
	end
endmodule // reset_and_power_mode_control_bench
`default_nettype wire
